// >>> rtl/dpf_pkg.sv
// Constants and decode helpers shared by the page and flag decoder.
package dpf_pkg;
   // ****************************************************************
   // Page window
   // ****************************************************************
   localparam int unsigned DPF_SW_W = 8;
   localparam int unsigned DPF_FIELD_CNT = 8;
   localparam int unsigned DPF_FIELD_IDX_W = 3;
   localparam int unsigned DPF_FIELD_SHIFT = 5;
   localparam int unsigned DPF_HADDR_W = 16;
   typedef enum logic [1:0] {
      DPF_PAGES_1 = 2'b00,
      DPF_PAGES_2 = 2'b01,
      DPF_PAGES_4 = 2'b10
   } dpf_pages_e;
   localparam logic [7:0] DPF_MASK_1 = 8'h01;
   localparam logic [7:0] DPF_MASK_2 = 8'h03;
   localparam logic [7:0] DPF_MASK_4 = 8'h07;
   // ****************************************************************
   // Coordination flag area
   // ****************************************************************
   localparam logic [15:0] DPF_FLAG_FIRST = 16'hF200;
   localparam logic [15:0] DPF_FLAG_LAST = 16'hF2FF;
   // ****************************************************************
   // Delivered switch settings, used as reset values and as the strap warning compare values
   // ****************************************************************
   localparam logic [7:0] DPF_DELIV_BASE = 8'h00;
   localparam logic [7:0] DPF_DELIV_FLAG_DIS = 8'hFF;
   localparam logic [5:0] DPF_CNT_UNUSED_HIGH = 6'h3F;
   localparam logic [7:0] DPF_RSVD_HIGH = 8'hFF;
   // ****************************************************************
   // Register port
   // ****************************************************************
   localparam int unsigned DPF_ADDR_W = 4;
   localparam int unsigned DPF_DATA_W = 16;
   localparam logic [3:0] DPF_REG_CTRL = 4'h0;
   localparam logic [3:0] DPF_REG_CFG = 4'h1;
   localparam logic [3:0] DPF_REG_FLAG = 4'h2;
   localparam logic [3:0] DPF_REG_LAST = 4'h3;
   localparam logic [3:0] DPF_REG_MISS = 4'h4;
   localparam logic [15:0] DPF_CTRL_RST = 16'h0003;
   localparam int unsigned DPF_CTRL_PAGE_BIT = 0;
   localparam int unsigned DPF_CTRL_FLAG_BIT = 1;
   localparam int unsigned DPF_CFG_CNT_LSB = 8;
   localparam int unsigned DPF_CFG_WARN_BIT = 14;
   localparam int unsigned DPF_CFG_VALID_BIT = 15;
   localparam int unsigned DPF_LAST_IDX_LSB = 8;
   localparam int unsigned DPF_LAST_P2_BIT = 10;
   localparam int unsigned DPF_LAST_MISS_BIT = 11;
   localparam int unsigned DPF_LAST_FLD_LSB = 12;
   localparam int unsigned DPF_LAST_FHIT_BIT = 15;

   // Decodes the two page count switches into a page count.
   function automatic dpf_pages_e dpf_decode_count(input logic [1:0] sw);
      if (!sw[1]) begin
         return DPF_PAGES_1;
      end else if (!sw[0]) begin
         return DPF_PAGES_2;
      end
      return DPF_PAGES_4;
   endfunction

   // Gives the page number bits that the match ignores.
   function automatic logic [7:0] dpf_low_mask(input dpf_pages_e cnt);
      case (cnt)
         DPF_PAGES_2: return DPF_MASK_2;
         DPF_PAGES_4: return DPF_MASK_4;
         default:     return DPF_MASK_1;
      endcase
   endfunction
endpackage

// >>> rtl/dpf_cfg_capture.sv
// Captures the static switch banks once after reset and holds them.
`timescale 1ns/100ps

module dpf_cfg_capture (
   // Clock and reset.
   input  wire logic                         clk_sys,
   input  wire logic                         rst_n,
   // Switch banks, a switch up reads as one.
   input  wire logic [dpf_pkg::DPF_SW_W-1:0] page_base_switches,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0] page_count_switches,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0] flag_field_disable_switches,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0] reserved_switch_bank,
   // Held configuration.
   output logic [dpf_pkg::DPF_SW_W-1:0]      base,
   output dpf_pkg::dpf_pages_e               count,
   output logic [dpf_pkg::DPF_SW_W-1:0]      mask,
   output logic [dpf_pkg::DPF_FIELD_CNT-1:0] field_en,
   output logic                              cfg_valid,
   output logic                              strap_warn
);
   import dpf_pkg::*;

   logic [DPF_SW_W-1:0]      next_base;
   dpf_pages_e               next_count;
   logic [DPF_FIELD_CNT-1:0] next_field_en;
   logic                     next_cfg_valid;
   logic                     next_strap_warn;

   // Takes the switches in the first cycle after reset, then holds.
   always_comb begin
      next_base = base;
      next_count = count;
      next_field_en = field_en;
      next_cfg_valid = 1'b1;
      next_strap_warn = strap_warn;
      if (!cfg_valid) begin
         next_base = page_base_switches;
         next_count = dpf_decode_count(page_count_switches[1:0]);
         next_field_en = ~flag_field_disable_switches;
         next_strap_warn = (page_count_switches[7:2] != DPF_CNT_UNUSED_HIGH) ||
                           (reserved_switch_bank != DPF_RSVD_HIGH);
      end
   end

   // Reset holds the delivered settings until the capture.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         base <= DPF_DELIV_BASE;
         count <= DPF_PAGES_1;
         field_en <= ~DPF_DELIV_FLAG_DIS;
         cfg_valid <= 1'b0;
         strap_warn <= 1'b0;
      end else begin
         base <= next_base;
         count <= next_count;
         field_en <= next_field_en;
         cfg_valid <= next_cfg_valid;
         strap_warn <= next_strap_warn;
      end
   end

   // The mask follows the held count.
   assign mask = dpf_low_mask(count);
endmodule

// >>> rtl/dpf_page_match.sv
// Matches a host page number against the configured page window.
`timescale 1ns/100ps

module dpf_page_match (
   // Configured window.
   input  wire logic [dpf_pkg::DPF_SW_W-1:0] base,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0] mask,
   // Page number from the host.
   input  wire logic [dpf_pkg::DPF_SW_W-1:0] page_num,
   // Match result.
   output logic                              hit,
   output logic                              odd,
   output logic [1:0]                        offset
);
   import dpf_pkg::*;

   logic [DPF_SW_W-1:0] low;

   // High bits must equal the base, low bits pick port and page.
   assign hit = ((page_num ^ base) & ~mask) == 8'h00;
   assign low = page_num & mask;
   assign odd = page_num[0];
   assign offset = low[2:1];
endmodule

// >>> rtl/dpf_page_flag_decode.sv
// Top level of the host page window and coordination flag decoder.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps

// What this block does
// - Even pages to port one, odd to two.
// - One, two or four pages per port.
// - Count switch one low selects one page.
// - Switch up reads one, down reads zero.
// - Base page from eight weighted base switches.
// - Further pages follow the base consecutively.
// - Low base bits ignored per page count.
// - Eight 32-byte flag fields, switch high disables.
// - Flag area spans F200 to F2FF.
// - Delivered flag switches high, fields disabled.
// - Delivered base zero, one page per port.
module dpf_page_flag_decode (
   // Clock and reset.
   input  wire logic                           clk_sys,
   input  wire logic                           rst_n,
   // Static switch banks.
   input  wire logic [dpf_pkg::DPF_SW_W-1:0]   page_base_switches,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0]   page_count_switches,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0]   flag_field_disable_switches,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0]   reserved_switch_bank,
   // Host page access.
   input  wire logic                           page_req,
   input  wire logic [dpf_pkg::DPF_SW_W-1:0]   page_num,
   // Host coordination flag access.
   input  wire logic                           flag_req,
   input  wire logic [dpf_pkg::DPF_HADDR_W-1:0] flag_addr,
   // Device port selection.
   output logic                                port1_sel,
   output logic                                port2_sel,
   output logic [1:0]                          page_idx,
   output logic                                page_miss,
   // Coordination flag result.
   output logic                                flag_hit,
   output logic                                flag_refused,
   output logic [dpf_pkg::DPF_FIELD_IDX_W-1:0] flag_field,
   // Switch setting warning.
   output logic                                strap_warn,
   // Register port.
   input  wire logic [dpf_pkg::DPF_ADDR_W-1:0] reg_addr,
   input  wire logic [dpf_pkg::DPF_DATA_W-1:0] reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic [dpf_pkg::DPF_DATA_W-1:0]      reg_rdata
);
   import dpf_pkg::*;

   // ****************************************************************
   // Configuration and page match
   // ****************************************************************
   logic [DPF_SW_W-1:0]        cfg_base;
   dpf_pages_e                 cfg_count;
   logic [DPF_SW_W-1:0]        cfg_mask;
   logic [DPF_FIELD_CNT-1:0]   cfg_field_en;
   logic                       cfg_valid;
   logic                       m_hit;
   logic                       m_odd;
   logic [1:0]                 m_off;

   // Switch capture, held for the whole run.
   dpf_cfg_capture u_cap (
      .clk_sys                     (clk_sys),
      .rst_n                       (rst_n),
      .page_base_switches          (page_base_switches),
      .page_count_switches         (page_count_switches),
      .flag_field_disable_switches (flag_field_disable_switches),
      .reserved_switch_bank        (reserved_switch_bank),
      .base                        (cfg_base),
      .count                       (cfg_count),
      .mask                        (cfg_mask),
      .field_en                    (cfg_field_en),
      .cfg_valid                   (cfg_valid),
      .strap_warn                  (strap_warn)
   );

   // Window compare for the current page number.
   dpf_page_match u_match (
      .base     (cfg_base),
      .mask     (cfg_mask),
      .page_num (page_num),
      .hit      (m_hit),
      .odd      (m_odd),
      .offset   (m_off)
   );

   // ****************************************************************
   // Decode results
   // ****************************************************************
   logic [DPF_DATA_W-1:0]      ctrl;
   logic                       page_en;
   logic                       flag_en;
   logic                       flag_in_area;
   logic [DPF_FIELD_IDX_W-1:0] flag_sel;
   logic                       next_port1_sel;
   logic                       next_port2_sel;
   logic [1:0]                 next_page_idx;
   logic                       next_page_miss;
   logic                       next_flag_hit;
   logic                       next_flag_refused;
   logic [DPF_FIELD_IDX_W-1:0] next_flag_field;

   // Decoding waits for the switch capture and the control enables.
   assign page_en = ctrl[DPF_CTRL_PAGE_BIT] & cfg_valid;
   assign flag_en = ctrl[DPF_CTRL_FLAG_BIT] & cfg_valid;
   assign flag_in_area = (flag_addr >= DPF_FLAG_FIRST) &&
                         (flag_addr <= DPF_FLAG_LAST);
   assign flag_sel = flag_addr[DPF_FIELD_SHIFT +: DPF_FIELD_IDX_W];

   // Works out the port, page and flag results of this cycle.
   always_comb begin
      next_port1_sel = 1'b0;
      next_port2_sel = 1'b0;
      next_page_idx = 2'b00;
      next_page_miss = 1'b0;
      next_flag_hit = 1'b0;
      next_flag_refused = 1'b0;
      next_flag_field = flag_field;
      if (page_req && page_en) begin
         if (m_hit) begin
            next_port1_sel = !m_odd;
            next_port2_sel = m_odd;
            next_page_idx = m_off;
         end else begin
            next_page_miss = 1'b1;
         end
      end
      if (flag_req && flag_en && flag_in_area) begin
         next_flag_field = flag_sel;
         next_flag_hit = cfg_field_en[flag_sel];
         next_flag_refused = !cfg_field_en[flag_sel];
      end
   end

   // Result outputs, each standing for one cycle except flag_field, which holds the last field.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         port1_sel <= 1'b0;
         port2_sel <= 1'b0;
         page_idx <= 2'b00;
         page_miss <= 1'b0;
         flag_hit <= 1'b0;
         flag_refused <= 1'b0;
         flag_field <= 3'h0;
      end else begin
         port1_sel <= next_port1_sel;
         port2_sel <= next_port2_sel;
         page_idx <= next_page_idx;
         page_miss <= next_page_miss;
         flag_hit <= next_flag_hit;
         flag_refused <= next_flag_refused;
         flag_field <= next_flag_field;
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   logic [DPF_DATA_W-1:0] miss_cnt;
   logic [DPF_DATA_W-1:0] last;
   logic [DPF_DATA_W-1:0] next_ctrl;
   logic [DPF_DATA_W-1:0] next_miss_cnt;
   logic [DPF_DATA_W-1:0] next_last;
   logic [DPF_DATA_W-1:0] next_reg_rdata;

   // Control, miss counter and last access record.
   always_comb begin
      next_ctrl = ctrl;
      next_miss_cnt = miss_cnt;
      next_last = last;
      if (reg_wr && reg_addr == DPF_REG_CTRL) begin
         next_ctrl = reg_wdata & DPF_CTRL_RST;
      end
      if (next_page_miss && miss_cnt != 16'hFFFF) begin
         next_miss_cnt = miss_cnt + 16'h0001;
      end
      if (reg_wr && reg_addr == DPF_REG_MISS) begin
         next_miss_cnt = next_page_miss ? 16'h0001 : 16'h0000;
      end
      if (page_req && page_en) begin
         next_last[DPF_SW_W-1:0] = page_num;
         next_last[DPF_LAST_IDX_LSB +: 2] = m_off;
         next_last[DPF_LAST_P2_BIT] = m_hit & m_odd;
         next_last[DPF_LAST_MISS_BIT] = !m_hit;
      end
      if (flag_req && flag_en && flag_in_area) begin
         next_last[DPF_LAST_FLD_LSB +: DPF_FIELD_IDX_W] = flag_sel;
         next_last[DPF_LAST_FHIT_BIT] = cfg_field_en[flag_sel];
      end
   end

   // Read data for the cycle after a read strobe, zero otherwise.
   always_comb begin
      next_reg_rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            DPF_REG_CTRL: next_reg_rdata = ctrl;
            DPF_REG_CFG: begin
               next_reg_rdata[DPF_SW_W-1:0] = cfg_base;
               next_reg_rdata[DPF_CFG_CNT_LSB +: 2] = cfg_count;
               next_reg_rdata[DPF_CFG_WARN_BIT] = strap_warn;
               next_reg_rdata[DPF_CFG_VALID_BIT] = cfg_valid;
            end
            DPF_REG_FLAG: next_reg_rdata[DPF_FIELD_CNT-1:0] = cfg_field_en;
            DPF_REG_LAST: next_reg_rdata = last;
            DPF_REG_MISS: next_reg_rdata = miss_cnt;
            default:      next_reg_rdata = 16'h0000;
         endcase
      end
   end

   // Register port state.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl <= DPF_CTRL_RST;
         miss_cnt <= 16'h0000;
         last <= 16'h0000;
         reg_rdata <= 16'h0000;
      end else begin
         ctrl <= next_ctrl;
         miss_cnt <= next_miss_cnt;
         last <= next_last;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking dpf_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // An even page in the window selects port one only.
   property p_even_port1;
      page_req && page_en && m_hit && !page_num[0] |=> port1_sel && !port2_sel;
   endproperty
   a_even_port1: assert property (p_even_port1)
      else $error("Even page did not select port one.");

   // An odd page in the window selects port two only.
   property p_odd_port2;
      page_req && page_en && m_hit && page_num[0] |=> port2_sel && !port1_sel;
   endproperty
   a_odd_port2: assert property (p_odd_port2)
      else $error("Odd page did not select port two.");

   // The page index is the offset above the base, halved.
   property p_page_index;
      page_req && page_en && m_hit |=>
         page_idx == 2'((($past(page_num) - (cfg_base & ~cfg_mask)) & cfg_mask) >> 1);
   endproperty
   a_page_index: assert property (p_page_index)
      else $error("Page index not consecutive from the base.");

   // A miss comes exactly when high bits differ from the base.
   property p_ignore_low;
      page_req && page_en |=>
         page_miss == ((($past(page_num) ^ cfg_base) & ~cfg_mask) != 8'h00);
   endproperty
   a_ignore_low: assert property (p_ignore_low)
      else $error("Page window match used the wrong bits.");

   // The capture takes the base and count from the switches.
   property p_capture;
      $rose(cfg_valid) |-> cfg_base == $past(page_base_switches) &&
         cfg_count == dpf_decode_count($past(page_count_switches[1:0]));
   endproperty
   a_capture: assert property (p_capture)
      else $error("Switch capture does not match the switches.");

   // Once captured, the decode stays constant.
   property p_static;
      cfg_valid |=> $stable(cfg_base) && $stable(cfg_count) && $stable(cfg_field_en);
   endproperty
   a_static: assert property (p_static)
      else $error("Captured configuration changed during run.");

   // A flag access names the 32-byte field from its address.
   property p_flag_field;
      flag_req && flag_en && flag_in_area |=>
         flag_field == $past(flag_addr[7:5]) && (flag_hit != flag_refused);
   endproperty
   a_flag_field: assert property (p_flag_field)
      else $error("Flag field decode wrong.");

   // A field whose switch is high is refused.
   property p_flag_disabled;
      flag_req && flag_en && flag_in_area &&
         flag_field_disable_switches[flag_sel] |=> flag_refused && !flag_hit;
   endproperty
   a_flag_disabled: assert property (p_flag_disabled)
      else $error("Disabled flag field was granted.");

   // Before the capture the delivered settings hold.
   property p_delivered;
      !cfg_valid |-> cfg_field_en == 8'h00 && cfg_base == DPF_DELIV_BASE &&
         cfg_count == DPF_PAGES_1;
   endproperty
   a_delivered: assert property (p_delivered)
      else $error("Delivered settings not held before capture.");

   // Main scenarios.
   c_port1: cover property (page_req && page_en && m_hit && !page_num[0]);
   c_port2_four: cover property (port2_sel && cfg_count == DPF_PAGES_4);
   c_miss: cover property (page_miss);
   c_flag_hit: cover property (flag_hit);
endmodule

// >>> verif/dpf_host_model.sv
// Host CPU model that issues page and flag accesses.
`timescale 1ns/100ps

module dpf_host_model (
   // Clock.
   input  wire logic                            clk_sys,
   // Host access lines.
   output logic                                 page_req,
   output logic [dpf_pkg::DPF_SW_W-1:0]         page_num,
   output logic                                 flag_req,
   output logic [dpf_pkg::DPF_HADDR_W-1:0]      flag_addr
);
   // Lines start idle.
   initial begin
      page_req = 1'b0;
      page_num = 8'h00;
      flag_req = 1'b0;
      flag_addr = 16'h0000;
   end

   // One page access per edge; it leaves the window only when the bench asks.
   task automatic page_go(input logic [7:0] n);
      @(posedge clk_sys);
      page_req <= 1'b1;
      page_num <= n;
      flag_req <= 1'b0;
      flag_addr <= ~flag_addr;
   endtask

   // One flag access per edge.
   task automatic flag_go(input logic [15:0] a);
      @(posedge clk_sys);
      flag_req <= 1'b1;
      flag_addr <= a;
      page_req <= 1'b0;
      page_num <= ~page_num;
   endtask

   // Released lines show the inverse of the last value, never a stale copy.
   task automatic idle();
      @(posedge clk_sys);
      page_req <= 1'b0;
      flag_req <= 1'b0;
      page_num <= ~page_num;
      flag_addr <= ~flag_addr;
   endtask
endmodule

// >>> verif/test_dpf_page_flag_decode.sv
// Self-checking bench for the page window and flag decoder.
`timescale 1ns/100ps

module test_dpf_page_flag_decode;
   import dpf_pkg::*;
   // ****************************************************************
   // Signals and model state
   // ****************************************************************
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  sw_base = 8'h00, sw_cnt = 8'hFE, sw_flag = 8'hFF, sw_rsvd = 8'hFF;
   logic        page_req, flag_req, port1_sel, port2_sel, page_miss;
   logic        flag_hit, flag_refused, strap_warn, rd_d = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  page_num, cap_base, cap_mask, cap_flag;
   logic [15:0] flag_addr, reg_rdata, miss_cnt, reg_wdata = 16'h0000;
   logic [3:0]  reg_addr = 4'h0;
   logic [2:0]  flag_field, last_fld;
   logic [1:0]  page_idx;
   logic [9:0]  obs, ev_q[$];
   logic [15:0] rd_q[$];
   int          bad_count = 0, tests_run = 0, m, k, seed;

   dpf_host_model dpf_host_model_inst (.clk_sys(clk_sys), .page_req(page_req),
      .page_num(page_num), .flag_req(flag_req), .flag_addr(flag_addr));
   dpf_page_flag_decode dpf_page_flag_decode_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .page_base_switches(sw_base), .page_count_switches(sw_cnt),
      .flag_field_disable_switches(sw_flag), .reserved_switch_bank(sw_rsvd),
      .page_req(page_req), .page_num(page_num), .flag_req(flag_req),
      .flag_addr(flag_addr), .port1_sel(port1_sel), .port2_sel(port2_sel),
      .page_idx(page_idx), .page_miss(page_miss), .flag_hit(flag_hit),
      .flag_refused(flag_refused), .flag_field(flag_field), .strap_warn(strap_warn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   // Clock at 125 MHz.
   always #4 clk_sys = ~clk_sys;
   // Observed result word of the page and flag groups.
   assign obs = {port1_sel, port2_sel, page_idx, page_miss, flag_hit, flag_refused, flag_field};

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic reg_op(input logic wr, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= wr;
      reg_rd <= ~wr;
      reg_addr <= a;
      reg_wdata <= d;
      if (!wr) rd_q.push_back(d);
   endtask

   task automatic reg_idle();
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask

   // Notes the expected routing, then issues the access.
   task automatic page(input logic [7:0] n, input logic en);
      if (en && ((n ^ cap_base) & ~cap_mask) == 8'h00)
         ev_q.push_back({~n[0], n[0], n[2:1] & cap_mask[2:1], 3'b000, last_fld});
      else if (en) begin
         ev_q.push_back({5'b00001, 2'b00, last_fld});
         miss_cnt++;
      end
      dpf_host_model_inst.page_go(n);
   endtask

   task automatic flag(input logic [15:0] a);
      if (a >= 16'hF200 && a <= 16'hF2FF) begin
         last_fld = a[7:5];
         ev_q.push_back({5'b00000, ~cap_flag[a[7:5]], cap_flag[a[7:5]], a[7:5]});
      end
      dpf_host_model_inst.flag_go(a);
   endtask

   task automatic drain();
      int t;
      for (t = 0; t < 50 && (ev_q.size() > 0 || rd_q.size() > 0); t++) @(posedge clk_sys);
      if (t == 50) begin
         bad_count++;
         final_report();
      end
   endtask

   // Takes the oldest note whenever a result shows and compares.
   always @(posedge clk_sys) rd_d <= reg_rd;
   always @(negedge clk_sys) begin
      if (|obs[9:3]) check("event", {6'h00, obs}, ev_q.size() ? ev_q.pop_front() : 16'hFFFF);
      if (rd_d) check("rdata", reg_rdata, rd_q.size() ? rd_q.pop_front() : 16'hFFFF);
      else if (reg_rdata !== 16'h0000) check("rdata idle", reg_rdata, 16'h0000);
   end

   // Main sequence: each page count, random base and flag switches.
   initial begin
      seed = $urandom(50958);
      for (m = 0; m < 5; m++) begin
         @(posedge clk_sys);
         rst_n <= 1'b0;
         sw_base <= $urandom;
         sw_flag <= $urandom;
         sw_cnt <= (m == 4) ? 8'h83 : {6'h3F, m[1:0]};
         sw_rsvd <= (m == 4) ? 8'h7F : 8'hFF;
         repeat (5) @(posedge clk_sys);
         rst_n <= 1'b1;
         cap_base = sw_base;
         cap_flag = sw_flag;
         cap_mask = !sw_cnt[1] ? 8'h01 : (!sw_cnt[0] ? 8'h03 : 8'h07);
         last_fld = 3'h0;
         miss_cnt = 16'h0000;
         @(posedge clk_sys);
         sw_base <= ~cap_base;
         reg_op(1'b0, DPF_REG_CTRL, DPF_CTRL_RST);
         // The warning flop settles at the capture edge, so it is looked at one edge later.
         check("warn", {15'h0, strap_warn}, {15'h0, m == 4});
         reg_op(1'b0, DPF_REG_CFG, {1'b1, m == 4, 4'h0, cap_mask[2],
                cap_mask[1] & ~cap_mask[2], cap_base});
         reg_op(1'b0, DPF_REG_FLAG, {8'h00, ~cap_flag});
         reg_idle();
         // Back-to-back page and flag accesses after the base switches moved.
         for (k = 0; k < 24; k++) begin
            page(k < 8 ? ((cap_base & ~cap_mask) | 8'(k)) : 8'($urandom), 1'b1);
            flag(16'hF1F0 + 16'($urandom_range(0, 303)));
         end
         dpf_host_model_inst.idle();
         drain();
         reg_op(1'b0, DPF_REG_MISS, miss_cnt);
         reg_op(1'b1, DPF_REG_MISS, 16'h0000);
         reg_op(1'b0, DPF_REG_MISS, 16'h0000);
         reg_op(1'b1, DPF_REG_CTRL, 16'h0000);
         reg_op(1'b1, DPF_REG_CFG, 16'hFFFF);
         reg_op(1'b0, 4'hF, 16'h0000);
         reg_op(1'b0, DPF_REG_CTRL, 16'h0000);
         reg_idle();
         // Decode turned off: no result may appear.
         page(cap_base, 1'b0);
         dpf_host_model_inst.idle();
         drain();
      end
      repeat (4) @(posedge clk_sys);
      final_report();
   end
endmodule
